// ### common/dswc_pkg.sv
package dswc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SETTLE = 8'h00;
  localparam logic [7:0] OFS_WAKE = 8'h04;
  localparam logic [7:0] OFS_KT = 8'h08;
  localparam logic [7:0] OFS_RSTAT = 8'h0C;
  localparam logic [7:0] OFS_MSTOP = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SET_MODE_BIT = 7;
  localparam int WAKE_NMI_BIT = 0;
  localparam int WAKE_PIN_LSB = 1;
  localparam int WAKE_SRF_BIT = 11;
  localparam int KT_KEY_BIT = 0;
  localparam int KT_TMR_LSB = 1;
  localparam int RSTAT_DEEP_BIT = 0;
  localparam int CMD_SLEEP_BIT = 0;
  localparam int PIN_COUNT = 10;
  localparam int TMR_COUNT = 5;
  localparam int PIN_SYNC_W = PIN_COUNT + 2;
  localparam int CNT_W = 20;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SETTLE_RST = 8'h05;
  localparam logic [31:0] MSTOP_RST = 32'hFFFF_0000;
  // nmi and irq pins idle low, the reset pin idles high
  localparam logic [PIN_SYNC_W-1:0] PIN_IDLE = 12'h800;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int OSC_DIV = 2048;
  localparam logic [10:0] OSC_DIV_LAST = 11'(OSC_DIV - 1);
  // ----------------------------------------------------------------
  // power sequencer states, gray along run-enter-deep-settle-run
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_ENTER = 3'h1,
    ST_DEEP = 3'h3,
    ST_SETTLE = 3'h2,
    ST_EXT_RST = 3'h6
  } dswc_state_type;
endpackage

// ### core/dswc_core.sv
`timescale 1ns/1ps
// Summary of operation
// - deep standby ends only on nmi, irq 0-9, key scan, slow timer or reset pin
// - exit starts when any pin, key scan or timer wake flag becomes 1
// - interrupt wake restarts oscillator, restores power, asserts chip reset
// - after settling, clock supplied, reset released, reset exception begins
// - every deep standby exit sets the deep wake reset flag
// - reset pin low restarts power and clock; exception starts when pin rises
// - wake during entry: entry is cancelled and the sequencer returns to run
// - mode bit 0: settle count field decodes to 64..524288 oscillator states
// - mode bit 1: count osc/2048 ticks until equal to settle count field
// - writing 1 to a module stop bit gates that module's clock
// - stop released by writing 0, or by reset for bits resetting to 0
// - register writes are posted; a dummy read makes them visible
// - wake request stays while an irq request flag is 1
// - timer or key scan cannot wake again until release flag is cleared
// - timer and key scan wake causes share one standby release interrupt
module dswc_core import dswc_pkg::*; #(
  parameter int SETTLE_SHIFT = 0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_nmi_pin,
  input wire logic [PIN_COUNT-1:0] i_irq_pin,
  input wire logic i_ext_reset_pin_n,
  input wire logic [PIN_COUNT-1:0] i_pin_irq_request_flag,
  input wire logic i_keyscan_event,
  input wire logic [TMR_COUNT-1:0] i_slow_timer_event,
  output logic o_power_on,
  output logic o_osc_run,
  output logic o_clock_supply,
  output logic o_chip_reset,
  output logic o_reset_exception,
  output logic o_deep_standby,
  output logic o_standby_release_irq,
  output logic [31:0] o_module_clk_en
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // hardware set wins over a software write-one clear
  function automatic logic [15:0] w1c(input logic [15:0] cur,
                                      input logic [15:0] set,
                                      input logic [15:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction

  function automatic logic [CNT_W-1:0] settle_states(input logic [6:0] code);
    logic [4:0] expo;
    expo = 5'h13;
    unique case (code)
      7'h05: expo = 5'h06;
      7'h06: expo = 5'h09;
      7'h07: expo = 5'h0A;
      7'h08: expo = 5'h0B;
      7'h09: expo = 5'h0C;
      7'h0A: expo = 5'h0E;
      7'h0B: expo = 5'h0F;
      7'h0C: expo = 5'h10;
      7'h0D: expo = 5'h11;
      7'h0E: expo = 5'h12;
      // reserved codes fall back to the longest setting, the safe side
      default: expo = 5'h13;
    endcase
    settle_states = CNT_W'(1) << expo;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_SYNC_W-1:0] pin_s1;
  logic [PIN_SYNC_W-1:0] pin_s2;
  logic [PIN_SYNC_W-1:0] pin_s3;
  logic [PIN_SYNC_W-1:0] pin_lvl;
  logic [PIN_SYNC_W-1:0] pin_raw;
  logic [PIN_COUNT:0] pin_rise;
  logic rst_pin_hi;

  assign pin_raw = {i_ext_reset_pin_n, i_irq_pin, i_nmi_pin};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      pin_lvl <= PIN_IDLE;
    end else if (i_clk_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // a change counts only once the last two stages agree
      pin_lvl <= (pin_lvl & (pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
    end
  end

  always_comb begin
    pin_rise = {(PIN_COUNT+1){1'b0}};
    pin_rise = (pin_s3[PIN_COUNT:0] & ~(pin_s2[PIN_COUNT:0] ^ pin_s3[PIN_COUNT:0]))
               & ~pin_lvl[PIN_COUNT:0];
  end

  assign rst_pin_hi = pin_lvl[PIN_SYNC_W-1];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [7:0] settle_ctrl;
  logic [15:0] wake_flags;
  logic [15:0] kt_flags;
  logic deep_wake_reset_flag;
  logic [31:0] module_stop_bit;
  logic sleep_cmd;
  dswc_state_type state;
  dswc_state_type next_state;

  // writes land at the access edge and the bus never waits on the
  // sequencer, so a write is posted and a read behind it sees it
  assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
  assign rd_setup = i_psel & ~i_penable;
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr <= OFS_STATE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_paddr)
      OFS_SETTLE: rd_mux = {24'h00_0000, settle_ctrl};
      OFS_WAKE: rd_mux = {16'h0000, wake_flags};
      OFS_KT: rd_mux = {16'h0000, kt_flags};
      OFS_RSTAT: rd_mux = {31'h0000_0000, deep_wake_reset_flag};
      OFS_MSTOP: rd_mux = module_stop_bit;
      OFS_STATE: rd_mux = {29'h0000_0000, state};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      o_pready <= rd_setup;
      o_pslverr <= rd_setup & ~addr_ok;
      if (rd_setup) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_ctrl <= SETTLE_RST;
      module_stop_bit <= MSTOP_RST;
      sleep_cmd <= 1'b0;
    end else if (i_clk_en) begin
      sleep_cmd <= wr_en && (i_paddr == OFS_CMD) && i_pwdata[CMD_SLEEP_BIT];
      if (wr_en && (i_paddr == OFS_SETTLE)) begin
        settle_ctrl <= i_pwdata[7:0];
      end
      if (wr_en && (i_paddr == OFS_MSTOP)) begin
        module_stop_bit <= i_pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // wake flags
  // ----------------------------------------------------------------
  logic [15:0] wake_set;
  logic [15:0] wake_clr;
  logic [15:0] kt_set;
  logic [15:0] kt_clr;
  logic kt_any;
  logic kt_wake;
  logic pin_wake;
  logic wake_req;
  logic [15:0] next_wake_flags;

  assign kt_any = i_keyscan_event | (|i_slow_timer_event);
  // a timer or key scan event wakes only while the release flag is clear
  assign kt_wake = kt_any & ~wake_flags[WAKE_SRF_BIT];
  // the irq request flag keeps the wake request alive on its own
  assign pin_wake = (|wake_flags[PIN_COUNT:0]) | (|i_pin_irq_request_flag);
  assign wake_req = pin_wake | kt_wake;

  always_comb begin
    wake_set = 16'h0000;
    wake_set[PIN_COUNT:0] = pin_rise;
    wake_set[WAKE_SRF_BIT] = kt_any;
    kt_set = 16'h0000;
    kt_set[KT_KEY_BIT] = i_keyscan_event;
    kt_set[KT_TMR_LSB +: TMR_COUNT] = i_slow_timer_event;
    wake_clr = (wr_en && (i_paddr == OFS_WAKE)) ? i_pwdata[15:0] : 16'h0000;
    kt_clr = (wr_en && (i_paddr == OFS_KT)) ? i_pwdata[15:0] : 16'h0000;
    next_wake_flags = w1c(wake_flags, wake_set, wake_clr) & 16'h0FFF;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_flags <= 16'h0000;
      kt_flags <= 16'h0000;
    end else if (i_clk_en) begin
      wake_flags <= next_wake_flags;
      kt_flags <= w1c(kt_flags, kt_set, kt_clr) & 16'h003F;
    end
  end

  // ----------------------------------------------------------------
  // settling counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cyc_cnt;
  logic [10:0] pre_cnt;
  logic [6:0] tick_cnt;
  logic [CNT_W-1:0] settle_target;
  logic settle_done;

  always_comb begin
    settle_target = settle_states(settle_ctrl[6:0]) >> SETTLE_SHIFT;
    if (settle_target == {CNT_W{1'b0}}) begin
      settle_target = CNT_W'(1);
    end
  end

  always_comb begin
    if (settle_ctrl[SET_MODE_BIT]) begin
      settle_done = (tick_cnt == settle_ctrl[6:0]);
    end else begin
      settle_done = (cyc_cnt == settle_target - CNT_W'(1));
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cyc_cnt <= {CNT_W{1'b0}};
      pre_cnt <= 11'h000;
      tick_cnt <= 7'h00;
    end else if (i_clk_en) begin
      if (state != ST_SETTLE) begin
        // every wake starts the count from zero
        cyc_cnt <= {CNT_W{1'b0}};
        pre_cnt <= 11'h000;
        tick_cnt <= 7'h00;
      end else begin
        cyc_cnt <= cyc_cnt + CNT_W'(1);
        pre_cnt <= (pre_cnt == OSC_DIV_LAST) ? 11'h000 : pre_cnt + 11'h001;
        if (pre_cnt == OSC_DIV_LAST) begin
          tick_cnt <= tick_cnt + 7'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // power sequencer
  // ----------------------------------------------------------------
  logic leaving;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (sleep_cmd) begin
          next_state = ST_ENTER;
        end
      end
      ST_ENTER: begin
        // a wake seen while entering cancels entry and the interrupt
        // is serviced before software may try again
        next_state = wake_req ? ST_RUN : ST_DEEP;
      end
      ST_DEEP: begin
        if (!rst_pin_hi) begin
          next_state = ST_EXT_RST;
        end else if (wake_req) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          next_state = ST_RUN;
        end
      end
      ST_EXT_RST: begin
        if (rst_pin_hi) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  assign leaving = (state == ST_SETTLE || state == ST_EXT_RST) && (next_state == ST_RUN);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RUN;
      o_power_on <= 1'b1;
      o_osc_run <= 1'b1;
      o_clock_supply <= 1'b1;
      o_chip_reset <= 1'b0;
      o_reset_exception <= 1'b0;
      o_deep_standby <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      o_power_on <= (next_state != ST_DEEP);
      o_osc_run <= (next_state != ST_DEEP);
      // during settling only the counter sees the clock
      o_clock_supply <= (next_state != ST_DEEP) && (next_state != ST_SETTLE);
      o_chip_reset <= (next_state == ST_SETTLE) || (next_state == ST_EXT_RST);
      o_reset_exception <= leaving;
      o_deep_standby <= (next_state == ST_DEEP);
    end
  end

  // ----------------------------------------------------------------
  // status and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      deep_wake_reset_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (leaving) begin
        deep_wake_reset_flag <= 1'b1;
      end else if (wr_en && (i_paddr == OFS_RSTAT) && i_pwdata[RSTAT_DEEP_BIT]) begin
        deep_wake_reset_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_standby_release_irq <= 1'b0;
      o_module_clk_en <= ~MSTOP_RST;
    end else if (i_clk_en) begin
      o_standby_release_irq <= next_wake_flags[WAKE_SRF_BIT];
      o_module_clk_en <= ~((wr_en && (i_paddr == OFS_MSTOP)) ? i_pwdata
                           : module_stop_bit);
    end
  end

endmodule // dswc_core

// ### testbench/dswc_core_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------
// sequencer and bus timing checks
// ------------------------------------------------
module dswc_core_checker import dswc_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_power_on,
  input wire logic o_osc_run,
  input wire logic o_clock_supply,
  input wire logic o_chip_reset,
  input wire logic o_reset_exception,
  input wire logic o_deep_standby,
  input wire logic [31:0] o_module_clk_en
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_deep_power_off: assert property (
    o_deep_standby |-> !(o_power_on || o_osc_run || o_clock_supply)) else $error("deep power");
  a_wake_power_up: assert property (
    $fell(o_deep_standby) |-> o_chip_reset && o_power_on && o_osc_run) else $error("wake power");
  a_exc_one_cycle: assert property (
    o_reset_exception |=> !o_reset_exception) else $error("exception width");
  a_exc_after_reset: assert property (
    $rose(o_reset_exception) |-> $past(o_chip_reset)) else $error("exception cause");
  a_release_clock_on: assert property (
    $fell(o_chip_reset) |-> o_clock_supply) else $error("clock at release");
  a_ready_next: assert property (
    i_psel && !i_penable |=> o_pready) else $error("ready late");
  a_ready_single: assert property (
    o_pready |=> !o_pready) else $error("ready width");
  a_stop_gates: assert property (
    i_psel && i_penable && o_pready && i_pwrite && i_paddr == OFS_MSTOP
    |=> ##1 o_module_clk_en == ~$past(i_pwdata, 2)) else $error("clock gate");
endmodule // dswc_core_checker

bind dswc_core dswc_core_checker i_dswc_core_checker (.i_ref_clk, .i_rst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_power_on, .o_osc_run,
  .o_clock_supply, .o_chip_reset, .o_reset_exception, .o_deep_standby, .o_module_clk_en);

// ### testbench/dswc_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// wake pins and event sources
// ------------------------------------------------
module dswc_pin_model import dswc_pkg::*; (
  input wire logic i_ref_clk,
  output logic o_nmi_pin,
  output logic [PIN_COUNT-1:0] o_irq_pin,
  output logic o_ext_reset_pin_n,
  output logic [PIN_COUNT-1:0] o_pin_irq_request_flag,
  output logic o_keyscan_event,
  output logic [TMR_COUNT-1:0] o_slow_timer_event
);
  // 0 reset pin, 1 nmi, 11:2 irq, 21:12 request, 22 key, 27:23 timer
  logic [27:0] pins = 28'h000_0001;
  assign {o_slow_timer_event, o_keyscan_event, o_pin_irq_request_flag, o_irq_pin,
    o_nmi_pin, o_ext_reset_pin_n} = pins;
  // a reset-pin wake lasts while the pin is held low, with no settling time
  task automatic drive(input logic [27:0] v, input int n);
    @(posedge i_ref_clk);
    pins <= v;
    repeat (n) @(posedge i_ref_clk);
    pins <= 28'h000_0001;
  endtask
endmodule // dswc_pin_model

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb import dswc_pkg::*; ;
  localparam int SHIFT = 10;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, o_module_clk_en, q;
  logic o_pready, o_pslverr, o_power_on, o_osc_run, o_clock_supply, o_chip_reset, e;
  logic o_reset_exception, o_deep_standby, o_standby_release_irq;
  logic i_nmi_pin, i_ext_reset_pin_n, i_keyscan_event;
  logic [PIN_COUNT-1:0] i_irq_pin, i_pin_irq_request_flag;
  logic [TMR_COUNT-1:0] i_slow_timer_event;
  int n_errors = 0, cmp_count = 0, n_exc = 0, cur = 0, last_len = 0;
  dswc_core #(.SETTLE_SHIFT(SHIFT)) i_dswc_core (.i_ref_clk, .i_rst, .i_clk_en(1'b1),
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_nmi_pin, .i_irq_pin, .i_ext_reset_pin_n, .i_pin_irq_request_flag,
    .i_keyscan_event, .i_slow_timer_event, .o_power_on, .o_osc_run, .o_clock_supply,
    .o_chip_reset, .o_reset_exception, .o_deep_standby, .o_standby_release_irq,
    .o_module_clk_en);
  dswc_pin_model i_dswc_pin_model (.i_ref_clk, .o_nmi_pin(i_nmi_pin),
    .o_irq_pin(i_irq_pin), .o_ext_reset_pin_n(i_ext_reset_pin_n),
    .o_pin_irq_request_flag(i_pin_irq_request_flag), .o_keyscan_event(i_keyscan_event),
    .o_slow_timer_event(i_slow_timer_event));
  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // ------------------------------------------------
  // exception pulses and length of the last reset span
  // ------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (o_reset_exception === 1'b1) n_exc++;
    if (o_chip_reset === 1'b1) cur++;
    else if (cur != 0) begin
      last_len = cur;
      cur = 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      t++;
    end while (o_pready !== 1'b1 && t < 20);
    if (t >= 20) n_errors++;
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic clear_flags();
    apb(1'b1, OFS_WAKE, 32'h0000_0FFF);
    apb(1'b1, OFS_KT, 32'h0000_003F);
    apb(1'b1, OFS_RSTAT, 32'h0000_0001);
  endtask
  task automatic go_deep();
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    repeat (3) @(posedge i_ref_clk);
    chk({31'h0, o_deep_standby}, 32'h0000_0001);
  endtask
  // wake may take a two-tick mode-1 settle of 4096 cycles, so the bound of 9000 is generous
  task automatic wait_run();
    int t;
    t = 0;
    do begin
      @(posedge i_ref_clk);
      t++;
    end while ((o_deep_standby !== 1'b0 || o_chip_reset !== 1'b0) && t < 9000);
    if (t >= 9000) n_errors++;
    repeat (2) @(posedge i_ref_clk);
  endtask
  task automatic s_reset_values();
    apb(1'b0, OFS_SETTLE, 32'h0000_0000);
    chk(q, 32'h0000_0005);
    apb(1'b0, OFS_MSTOP, 32'h0000_0000);
    chk(q, 32'hFFFF_0000);
    chk(o_module_clk_en, 32'h0000_FFFF);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
  endtask
  task automatic s_module_stop();
    apb(1'b1, OFS_MSTOP, 32'h0000_00F0);
    repeat (2) @(posedge i_ref_clk);
    chk(o_module_clk_en, 32'hFFFF_FF0F);
    apb(1'b1, OFS_MSTOP, 32'h0000_0000);
    apb(1'b0, OFS_MSTOP, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(o_module_clk_en, 32'hFFFF_FFFF);
  endtask
  task automatic s_wake_sources();
    int b;
    int x;
    apb(1'b1, OFS_SETTLE, 32'h0000_0080);
    for (int k = 0; k < 17; k++) begin
      b = k < 11 ? k + 1 : k + 11;
      x = n_exc;
      clear_flags();
      go_deep();
      i_dswc_pin_model.drive(28'h000_0001 | (28'h000_0001 << b), k < 11 ? 4 : 1);
      wait_run();
      chk(n_exc, x + 1);
      apb(1'b0, OFS_RSTAT, 32'h0000_0000);
      chk(q, 32'h0000_0001);
    end
  endtask
  task automatic s_settle_time();
    logic [7:0] v [5] = '{8'h05, 8'h0D, 8'h0F, 8'h7F, 8'h82};
    int lo [5] = '{1, 131072 >> SHIFT, 524288 >> SHIFT, 524288 >> SHIFT, 2 * OSC_DIV};
    int hi [5] = '{2, (131072 >> SHIFT) + 1, (524288 >> SHIFT) + 1,
      (524288 >> SHIFT) + 1, 2 * OSC_DIV + 2};
    for (int k = 0; k < 5; k++) begin
      clear_flags();
      apb(1'b1, OFS_SETTLE, {24'h0, v[k]});
      go_deep();
      i_dswc_pin_model.drive(28'h000_0003, 4);
      wait_run();
      chk({31'h0, last_len >= lo[k] && last_len <= hi[k]}, 32'h0000_0001);
    end
  endtask
  task automatic s_reset_pin();
    int x;
    x = n_exc;
    clear_flags();
    go_deep();
    fork
      i_dswc_pin_model.drive(28'h000_0000, 40);
      begin
        repeat (20) @(posedge i_ref_clk);
        chk({28'h0, o_chip_reset, o_clock_supply, o_power_on, o_osc_run}, 32'hF);
        chk(n_exc, x);
      end
    join
    wait_run();
    chk(n_exc, x + 1);
    apb(1'b0, OFS_RSTAT, 32'h0000_0000);
    chk(q, 32'h0000_0001);
  endtask
  task automatic s_release_flag();
    clear_flags();
    go_deep();
    i_dswc_pin_model.drive(28'h040_0001, 1);
    wait_run();
    chk({31'h0, o_standby_release_irq}, 32'h0000_0001);
    apb(1'b1, OFS_KT, 32'h0000_003F);
    go_deep();
    i_dswc_pin_model.drive(28'h080_0001, 1);
    repeat (20) @(posedge i_ref_clk);
    chk({31'h0, o_deep_standby}, 32'h0000_0001);
    apb(1'b1, OFS_WAKE, 32'h0000_0800);
    i_dswc_pin_model.drive(28'h100_0001, 1);
    wait_run();
    chk({31'h0, o_deep_standby}, 32'h0000_0000);
  endtask
  task automatic s_entry_pending();
    clear_flags();
    fork
      i_dswc_pin_model.drive(28'h000_1001, 30);
      begin
        repeat (2) @(posedge i_ref_clk);
        apb(1'b1, OFS_CMD, 32'h0000_0001);
        repeat (3) @(posedge i_ref_clk);
        chk({31'h0, o_deep_standby}, 32'h0000_0000);
      end
    join
  endtask
  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    s_reset_values();
    s_module_stop();
    s_wake_sources();
    s_settle_time();
    s_reset_pin();
    s_release_flag();
    s_entry_pending();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    n_errors++;
    complete_run();
  end
endmodule // tb
